/* File: alarm_defines.vh */
// Constants for the error monitor, alarm pin and error log block.
// Included by the error monitor design file only; holds definitions only.
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

// Configuration memory byte addresses
`define ADR_ALARM_MASK 8'h14
`define ADR_ALARM_CFG 8'h15
`define ADR_DRV_MASK 8'h16
`define ADR_LOG_MASK_LO 8'h17
`define ADR_LOG_MASK_HI 8'h18
`define ADR_FIRST_LOG 8'h20
`define ADR_LAST_LOG 8'h21
`define ADR_CUM_LOG 8'h22

// Field positions
`define POLARITY_BIT 2
`define HOLD_MSB 5
`define HOLD_LSB 3
`define PULLUP_BIT 2
`define REACT_BIT 6

// Event bit positions
`define EV_LOSS 0
`define EV_CLIP 1
`define EV_CTL_MIN 2
`define EV_CTL_MAX 3
`define EV_EXT 4
`define EV_TEMP 5
`define EV_CFG 6
`define NUM_EVENTS 7

// Reset values
`define RST_BYTE 8'h00

// Timing
`define CLK_HZ 25000000
`define HOLD_STEP_US 12500
`define HOLD_STEP_CYC ((`CLK_HZ / 1000) * `HOLD_STEP_US / 1000)

`endif

/* File: log_memory.v */
// Small configuration and error-log memory, byte wide.
// Assumes a single writer port and one read port on i_clk; read data
// come out of a register one cycle after the address.
`timescale 1ns/1ps
module log_memory #(
    parameter ADDR_W = 8
) (
    input wire i_clk,
    input wire i_we,
    input wire [ADDR_W-1:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [ADDR_W-1:0] i_raddr,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

/* File: error_alarm.v */
// Error monitor: masks events onto the alarm pin and driver shutdown,
// and keeps first, last and cumulative error logs in memory.
// Assumes analog events arrive already synchronous to i_clk except the alarm
// pin, test level, over-temperature and below-ground comparators, synchronised here.
// The memory stands in for the external nonvolatile store; its contents
// are loaded and saved by logic outside this block.
`timescale 1ns/1ps
`include "alarm_defines.vh"

// Overview of operation
// - Loss of signal is event bit 0 in masks and logs.
// - Configuration error keeps drivers tristate across power cycles.
// - First enabled logged error after power-on goes to first-error log.
// - Most recent enabled logged error goes to last-error log.
// - Cumulative log bit set to 1 once its event occurs.
// - Logs store occurrence only, no time and no count.
// - Alarm pin is open drain with pull-up switched by enable bit.
// - Alarm pin input signals the external system error event.
// - Polarity bit 0: low on error; 1 inverts; input alike.
// - Three-bit field selects minimum indication 0 to 87.5 ms.
// - Reactivation 0: drivers return when clear; 1: only after power-on, except after a request that starts and ends during logging.
// - Over-temperature warning routes through masks to alarm or shutdown.
// - Shutdown temperature disables drivers regardless of driver mask.
// - Outputs stay tristate during start-up until configured.
// - Below-ground fault in start-up keeps device unconfigured, tristate.
// - Alarm pin above test threshold enters test mode.
// - Alarm, driver and log masks gate pin, shutdown and storage.
// - Bits 6..1: config, temp, external, ctl max, ctl min, clipping.
// - Config error: bus pin fault, missing acknowledge or bad checksum.
module error_alarm #(
    parameter HOLD_STEP = `HOLD_STEP_CYC
) (
    input wire i_clk,
    input wire i_srst,
    // Configuration memory load port from the start-up loader
    input wire i_cfg_we,
    input wire [7:0] i_cfg_addr,
    input wire [7:0] i_cfg_wdata,
    input wire [7:0] i_rd_addr,
    output wire [7:0] o_rd_data,
    input wire i_cfg_done,
    // Configuration error causes
    input wire i_bus_pin_fault,
    input wire i_no_ack,
    input wire i_bad_checksum,
    input wire i_cfg_err_sticky,
    // Internal events
    input wire i_loss_of_signal,
    input wire i_clipping,
    input wire i_ctl_at_min,
    input wire i_ctl_at_max,
    input wire i_temp_warn,
    input wire i_temp_shutdown,
    input wire i_below_ground,
    // Alarm pin
    input wire i_alarm_pin,
    input wire i_alarm_test_level,
    output reg o_alarm_out,
    output reg o_alarm_oe_n,
    output reg o_alarm_pullup,
    // Line drivers and state
    output reg o_driver_enable,
    output reg o_cfg_err_store,
    output reg o_test_mode,
    output reg [6:0] o_active_events
);
    localparam ST_START = 4'b0001;
    localparam ST_RUN = 4'b0010;
    localparam ST_DEAD = 4'b0100;
    localparam ST_LOG = 4'b1000;

    // Take the low 7 bits of a byte as a 7-bit event vector
    function [6:0] ev7;
        input [7:0] b;
        begin
            ev7 = b[6:0];
        end
    endfunction

    // Configuration shadow registers
    reg [6:0] alarm_mask;
    reg [6:0] drv_mask;
    reg [6:0] log_mask;
    reg polarity;
    reg [2:0] hold_sel;
    reg pullup_en;
    reg react_sel;

    always @(posedge i_clk) begin
        if (i_srst) begin
            alarm_mask <= 7'h00;
            drv_mask <= 7'h00;
            log_mask <= 7'h00;
            polarity <= 1'b0;
            hold_sel <= 3'h0;
            pullup_en <= 1'b0;
            react_sel <= 1'b0;
        end else if (i_cfg_we) begin
            case (i_cfg_addr)
                `ADR_ALARM_MASK: alarm_mask <= ev7(i_cfg_wdata);
                `ADR_DRV_MASK: drv_mask <= ev7(i_cfg_wdata);
                `ADR_ALARM_CFG: begin
                    polarity <= i_cfg_wdata[`POLARITY_BIT];
                    hold_sel <= i_cfg_wdata[`HOLD_MSB:`HOLD_LSB];
                end
                `ADR_LOG_MASK_LO: begin
                    pullup_en <= i_cfg_wdata[`PULLUP_BIT];
                    log_mask[3:0] <= i_cfg_wdata[7:4];
                end
                `ADR_LOG_MASK_HI: begin
                    log_mask[6:4] <= i_cfg_wdata[2:0];
                    react_sel <= i_cfg_wdata[`REACT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Pin and comparator synchronisers
    reg [1:0] pin_s;
    reg [1:0] test_s;
    reg [1:0] tw_s;
    reg [1:0] ts_s;
    reg [1:0] bg_s;
    always @(posedge i_clk) begin
        if (i_srst) begin
            pin_s <= 2'b11;
            test_s <= 2'b00;
            tw_s <= 2'b00;
            ts_s <= 2'b00;
            bg_s <= 2'b00;
        end else begin
            pin_s <= {pin_s[0], i_alarm_pin};
            test_s <= {test_s[0], i_alarm_test_level};
            tw_s <= {tw_s[0], i_temp_warn};
            ts_s <= {ts_s[0], i_temp_shutdown};
            bg_s <= {bg_s[0], i_below_ground};
        end
    end

    reg [3:0] state;
    reg drive_err;
    wire running = (state == ST_RUN) | (state == ST_LOG);
    wire drive_low = running & (drive_err ^ polarity);

    // Our own pin changes reach the synchroniser three edges late, so
    // the input is ignored until the drive level has been steady as long
    reg [2:0] drive_hist;
    wire pin_quiet = (drive_hist == {3{drive_low}});
    always @(posedge i_clk) begin
        if (i_srst) begin
            drive_hist <= 3'h0;
        end else begin
            drive_hist <= {drive_hist[1:0], drive_low};
        end
    end

    // Pin level seen while we do not signal an error ourselves
    wire pin_level = pin_s[1];
    wire ext_level = polarity ? pin_level : !pin_level;
    wire ext_err = !drive_err & pin_quiet & ext_level;
    wire cfg_err = i_bus_pin_fault | i_no_ack | i_bad_checksum;

    // Event vector, bit layout fixed
    wire [6:0] events;
    assign events[`EV_LOSS] = i_loss_of_signal;
    assign events[`EV_CLIP] = i_clipping;
    assign events[`EV_CTL_MIN] = i_ctl_at_min;
    assign events[`EV_CTL_MAX] = i_ctl_at_max;
    assign events[`EV_EXT] = ext_err & running;
    assign events[`EV_TEMP] = tw_s[1];
    assign events[`EV_CFG] = cfg_err;

    // Own errors only; the external one would latch itself via the pin
    wire [6:0] internal_ev = events & ~(7'h01 << `EV_EXT);
    wire alarm_req = |(internal_ev & alarm_mask);
    wire shut_req = |(events & drv_mask) | ts_s[1];

    // Minimum indication time, in steps of HOLD_STEP cycles
    reg [23:0] step_cnt;
    reg [2:0] steps_left;
    wire step_tick = (step_cnt == HOLD_STEP - 1);
    always @(posedge i_clk) begin
        if (i_srst) begin
            drive_err <= 1'b0;
            step_cnt <= 24'h000000;
            steps_left <= 3'h0;
        end else if (alarm_req) begin
            drive_err <= 1'b1;
            step_cnt <= 24'h000000;
            steps_left <= hold_sel;
        end else if (drive_err) begin
            if (steps_left == 3'h0) begin
                drive_err <= 1'b0;
            end else if (step_tick) begin
                step_cnt <= 24'h000000;
                steps_left <= steps_left - 3'h1;
            end else begin
                step_cnt <= step_cnt + 24'h000001;
            end
        end
    end

    // Start-up, run and permanent-tristate sequencing
    reg latched_off;
    reg [6:0] seen;
    reg first_done;
    reg [6:0] first_log;
    reg [6:0] last_log;
    reg [6:0] cum_log;
    reg [6:0] new_ev;
    reg [1:0] log_step;

    wire [6:0] log_ev = events & log_mask;
    wire [6:0] rising = log_ev & ~seen;

    always @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_START;
            latched_off <= 1'b0;
            seen <= 7'h00;
            first_done <= 1'b0;
            first_log <= 7'h00;
            last_log <= 7'h00;
            cum_log <= 7'h00;
            new_ev <= 7'h00;
            log_step <= 2'h0;
            o_cfg_err_store <= 1'b0;
        end else begin
            case (state)
                ST_START: begin
                    if (bg_s[1]) begin
                        state <= ST_DEAD;
                    end else if (i_cfg_err_sticky) begin
                        state <= ST_DEAD;
                    end else if (cfg_err) begin
                        o_cfg_err_store <= 1'b1;
                        state <= ST_DEAD;
                    end else if (i_cfg_done) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cfg_err) begin
                        o_cfg_err_store <= 1'b1;
                        latched_off <= 1'b1;
                    end
                    if (shut_req && react_sel) begin
                        latched_off <= 1'b1;
                    end
                    if (|rising) begin
                        seen <= seen | rising;
                        new_ev <= rising;
                        log_step <= 2'h0;
                        state <= ST_LOG;
                    end
                end
                ST_LOG: begin
                    // A config error must not slip past while logging
                    if (cfg_err) begin
                        o_cfg_err_store <= 1'b1;
                        latched_off <= 1'b1;
                    end
                    // Three byte writes: first (once), last, cumulative
                    log_step <= log_step + 2'h1;
                    if (log_step == 2'h0) begin
                        if (!first_done) begin
                            first_log <= new_ev;
                            first_done <= 1'b1;
                        end
                    end else if (log_step == 2'h1) begin
                        last_log <= new_ev;
                    end else begin
                        cum_log <= cum_log | new_ev;
                        state <= ST_RUN;
                    end
                end
                ST_DEAD: begin
                    state <= ST_DEAD;
                end
                default: state <= ST_START;
            endcase
            if (!(|log_ev)) begin
                seen <= 7'h00;
            end
        end
    end

    // Memory write mux: configuration load or log update
    wire log_we = (state == ST_LOG) & ((log_step != 2'h0) | !first_done);
    reg [7:0] log_addr;
    reg [7:0] log_data;
    always @* begin
        case (log_step)
            2'h0: begin
                log_addr = `ADR_FIRST_LOG;
                log_data = {1'b0, new_ev};
            end
            2'h1: begin
                log_addr = `ADR_LAST_LOG;
                log_data = {1'b0, new_ev};
            end
            default: begin
                log_addr = `ADR_CUM_LOG;
                log_data = {1'b0, cum_log | new_ev};
            end
        endcase
    end

    log_memory #(
        .ADDR_W(8)
    ) u_mem (
        .i_clk(i_clk),
        .i_we(i_cfg_we | log_we),
        .i_waddr(i_cfg_we ? i_cfg_addr : log_addr),
        .i_wdata(i_cfg_we ? i_cfg_wdata : log_data),
        .i_raddr(i_rd_addr),
        .o_rdata(o_rd_data)
    );

    // Registered pin and driver outputs
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_alarm_out <= 1'b0;
            o_alarm_oe_n <= 1'b1;
            o_alarm_pullup <= 1'b0;
            o_driver_enable <= 1'b0;
            o_test_mode <= 1'b0;
            o_active_events <= 7'h00;
        end else begin
            o_alarm_out <= 1'b0;
            // Low on error at polarity 0, low when clear at polarity 1
            o_alarm_oe_n <= !drive_low;
            o_alarm_pullup <= pullup_en;
            o_driver_enable <= running & !shut_req &
                !latched_off;
            o_test_mode <= test_s[1];
            o_active_events <= events;
        end
    end
endmodule

/* File: error_alarm_checker.sv */
// Assertion checker for the error monitor, bound to its top module.
// Assumes i_clk at 25 MHz and synchronous active-high i_srst.
`timescale 1ns/1ps
module error_alarm_checker #(
    parameter HOLD_STEP = 10
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_cfg_we,
    input wire [7:0] i_cfg_addr,
    input wire [7:0] i_cfg_wdata,
    input wire i_cfg_done,
    input wire i_no_ack,
    input wire i_loss_of_signal,
    input wire i_clipping,
    input wire i_temp_shutdown,
    input wire i_alarm_test_level,
    input wire o_alarm_out,
    input wire o_alarm_oe_n,
    input wire o_driver_enable,
    input wire o_cfg_err_store,
    input wire o_test_mode,
    input wire [6:0] o_active_events
);
    reg seen_done;
    reg hold_nz;
    reg pol;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Shadow of the hold and polarity fields, so the hold check knows
    // when a minimum indication is really asked for
    always @(posedge i_clk) begin
        if (i_srst) begin
            seen_done <= 1'b0;
            hold_nz <= 1'b0;
            pol <= 1'b0;
        end else begin
            if (i_cfg_done)
                seen_done <= 1'b1;
            if (i_cfg_we && i_cfg_addr == 8'h15) begin
                hold_nz <= |i_cfg_wdata[5:3];
                pol <= i_cfg_wdata[2];
            end
        end
    end
    a_pin_never_high: assert property (o_alarm_out == 1'b0)
        else $error("alarm pin driven high");
    a_startup_tristate: assert property (
        !seen_done |-> !o_driver_enable)
        else $error("drivers on before configuration");
    // Reset itself must not disable this one, or it could never fire
    a_reset_quiet: assert property (@(posedge i_clk)
        disable iff (1'b0) i_srst |=>
        o_alarm_oe_n && !o_driver_enable && o_active_events == 7'h00)
        else $error("outputs active after reset");
    a_hot_shutdown: assert property (i_temp_shutdown [*4] |=>
        !o_driver_enable) else $error("drivers on above shutdown temp");
    a_test_entry: assert property (i_alarm_test_level [*4] |=>
        o_test_mode) else $error("test mode not entered");
    a_min_hold: assert property (
        $fell(o_alarm_oe_n) && hold_nz && !pol |=> (!o_alarm_oe_n) [*8])
        else $error("alarm released too soon");
    a_loss_bit: assert property (
        (seen_done && i_loss_of_signal) [*2] |=> o_active_events[0])
        else $error("loss event not on bit 0");
    a_clip_bit: assert property ((seen_done && i_clipping) [*2]
        |=> o_active_events[1]) else $error("clip event not on bit 1");
    a_cfg_store: assert property ((seen_done && i_no_ack) [*2]
        |=> ##[0:3] o_cfg_err_store) else $error("config error not stored");
    a_cfg_dead: assert property (o_cfg_err_store |=> ##[0:2]
        !o_driver_enable) else $error("drivers on after config error");
    c_alarm: cover property ($fell(o_alarm_oe_n));
    c_drv_off: cover property ($fell(o_driver_enable));
    c_test: cover property ($rose(o_test_mode));
    c_cfg_err: cover property ($rose(o_cfg_err_store));
endmodule
bind error_alarm error_alarm_checker #(.HOLD_STEP(HOLD_STEP))
    error_alarm_checker_inst (.*);

/* File: alarm_line_host.sv */
// Far-side controller on the open-drain alarm line.
// Assumes the bench raises i_pull_low to post an external error.
`timescale 1ns/1ps
module alarm_line_host (
    input wire i_clk,
    input wire i_dev_oe_n,
    input wire i_pullup,
    input wire i_pull_low,
    output wire o_pin
);
    reg float_lvl = 1'b0;
    // Unpulled wire drifts, so a stale level never looks valid
    always @(posedge i_clk) begin
        float_lvl <= ~float_lvl;
    end
    // Either party may pull low; only the pull-up lifts it
    assign o_pin = (!i_dev_oe_n || i_pull_low) ? 1'b0 :
        (i_pullup ? 1'b1 : float_lvl);
endmodule

/* File: error_alarm_tb_top.sv */
// Self-checking bench for the error monitor with the alarm line host.
// Assumes a 40 ns clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module error_alarm_tb_top;
    localparam HS = 10;
    reg i_clk = 1'b0;
    reg i_srst, i_cfg_we, i_cfg_done, i_bus_pin_fault, i_no_ack;
    reg i_bad_checksum, i_cfg_err_sticky, i_loss_of_signal, i_clipping;
    reg i_ctl_at_min, i_ctl_at_max, i_temp_warn, i_temp_shutdown;
    reg i_below_ground, i_alarm_test_level, pull_low;
    reg [7:0] i_cfg_addr, i_cfg_wdata, i_rd_addr;
    wire i_alarm_pin, o_alarm_out, o_alarm_oe_n, o_alarm_pullup;
    wire o_driver_enable, o_cfg_err_store, o_test_mode;
    wire [7:0] o_rd_data;
    wire [6:0] o_active_events;
    integer errors, n_checks, k;
    error_alarm #(.HOLD_STEP(HS)) error_alarm_inst (.*);
    alarm_line_host alarm_line_host_inst (.i_clk(i_clk),
        .i_dev_oe_n(o_alarm_oe_n), .i_pullup(o_alarm_pullup),
        .i_pull_low(pull_low), .o_pin(i_alarm_pin));
    always #20 i_clk = ~i_clk;
    task test_done;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge i_clk);
            #1;
        end
    endtask
    task chk1(input got, input exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t: bit %b not %b", $time, got, exp);
            end
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t: byte %h not %h", $time, got, exp);
            end
        end
    endtask
    task cfg_wr(input [7:0] a, input [7:0] d);
        begin
            i_cfg_we = 1'b1;
            i_cfg_addr = a;
            i_cfg_wdata = d;
            tick(1);
            i_cfg_we = 1'b0;
            tick(1);
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp);
        begin
            i_rd_addr = a;
            tick(2);
            chk8(o_rd_data, exp);
        end
    endtask
    // Mid-run reset; drops configuration done so start-up is seen again
    task restart;
        begin
            i_cfg_done = 1'b0;
            i_srst = 1'b1;
            tick(2);
            i_srst = 1'b0;
            tick(1);
        end
    endtask
    // Bounded wait on the alarm enable; a hang ends the run
    task wait_oe(input v);
        begin
            k = 0;
            while (o_alarm_oe_n !== v && k < 40) begin
                tick(1);
                k = k + 1;
            end
            if (o_alarm_oe_n !== v) begin
                errors = errors + 1;
                $display("mismatch at %0t: alarm wait ran out", $time);
                test_done;
            end
        end
    endtask
    initial begin
        {i_cfg_we, i_cfg_done, i_bus_pin_fault, i_no_ack, i_bad_checksum,
            i_cfg_err_sticky, i_loss_of_signal, i_clipping, i_ctl_at_min,
            i_ctl_at_max, i_temp_warn, i_temp_shutdown, i_below_ground,
            i_alarm_test_level, pull_low} = 15'h0000;
        {i_cfg_addr, i_cfg_wdata, i_rd_addr} = 24'h000000;
        i_srst = 1'b1;
        errors = 0;
        n_checks = 0;
        tick(16);
        i_srst = 1'b0;
        tick(1);
        chk1(o_alarm_oe_n, 1'b1);
        // All alarms on, hold 2 steps, warning shuts drivers, log all
        cfg_wr(8'h14, 8'h7f);
        cfg_wr(8'h15, 8'h10);
        cfg_wr(8'h16, 8'h20);
        cfg_wr(8'h17, 8'hf4);
        cfg_wr(8'h18, 8'h07);
        chk1(o_driver_enable, 1'b0);
        i_cfg_done = 1'b1;
        tick(3);
        chk1(o_driver_enable, 1'b1);
        chk1(o_alarm_pullup, 1'b1);
        chk1(i_alarm_pin, 1'b1);
        i_loss_of_signal = 1'b1;
        tick(2);
        i_loss_of_signal = 1'b0;
        tick(3);
        chk1(o_alarm_oe_n, 1'b0);
        tick(12);
        chk1(o_alarm_oe_n, 1'b0);
        wait_oe(1'b1);
        rd_chk(8'h20, 8'h01);
        rd_chk(8'h21, 8'h01);
        rd_chk(8'h22, 8'h01);
        i_clipping = 1'b1;
        tick(2);
        i_clipping = 1'b0;
        tick(3);
        wait_oe(1'b1);
        rd_chk(8'h20, 8'h01);
        rd_chk(8'h21, 8'h02);
        rd_chk(8'h22, 8'h03);
        {i_ctl_at_min, i_ctl_at_max} = 2'b11;
        tick(2);
        {i_ctl_at_min, i_ctl_at_max} = 2'b00;
        tick(3);
        wait_oe(1'b1);
        rd_chk(8'h21, 8'h0c);
        rd_chk(8'h22, 8'h0f);
        i_temp_warn = 1'b1;
        tick(6);
        chk1(o_driver_enable, 1'b0);
        chk1(o_alarm_oe_n, 1'b0);
        i_temp_warn = 1'b0;
        tick(3);
        wait_oe(1'b1);
        tick(3);
        chk1(o_driver_enable, 1'b1);
        cfg_wr(8'h16, 8'h00);
        i_temp_shutdown = 1'b1;
        tick(6);
        chk1(o_driver_enable, 1'b0);
        i_temp_shutdown = 1'b0;
        tick(6);
        chk1(o_driver_enable, 1'b1);
        pull_low = 1'b1;
        tick(6);
        chk1(o_active_events[4], 1'b1);
        chk1(o_alarm_oe_n, 1'b1);
        pull_low = 1'b0;
        tick(6);
        i_no_ack = 1'b1;
        tick(6);
        chk1(o_cfg_err_store, 1'b1);
        i_no_ack = 1'b0;
        tick(6);
        chk1(o_driver_enable, 1'b0);
        i_alarm_test_level = 1'b1;
        tick(6);
        chk1(o_test_mode, 1'b1);
        i_alarm_test_level = 1'b0;
        // Inverted polarity; a clipping shutdown latches the drivers off
        restart;
        chk1(o_alarm_oe_n, 1'b1);
        cfg_wr(8'h14, 8'h02);
        cfg_wr(8'h15, 8'h04);
        cfg_wr(8'h16, 8'h02);
        cfg_wr(8'h17, 8'h04);
        cfg_wr(8'h18, 8'h40);
        chk1(o_cfg_err_store, 1'b0);
        i_cfg_done = 1'b1;
        tick(3);
        chk1(o_alarm_oe_n, 1'b0);
        chk1(o_driver_enable, 1'b1);
        i_clipping = 1'b1;
        tick(2);
        chk1(o_alarm_oe_n, 1'b1);
        chk1(o_driver_enable, 1'b0);
        i_clipping = 1'b0;
        tick(6);
        chk1(o_alarm_oe_n, 1'b0);
        chk1(o_driver_enable, 1'b0);
        chk1(o_active_events[4], 1'b0);
        // Below-ground start-up, then a stored configuration error
        i_below_ground = 1'b1;
        restart;
        tick(3);
        i_cfg_done = 1'b1;
        tick(3);
        chk1(o_driver_enable, 1'b0);
        chk1(o_alarm_oe_n, 1'b1);
        i_below_ground = 1'b0;
        i_cfg_err_sticky = 1'b1;
        restart;
        i_cfg_done = 1'b1;
        tick(3);
        chk1(o_driver_enable, 1'b0);
        test_done;
    end
endmodule
